/* core/scan_tap.sv */
// Purpose: Boundary-scan test access port with AC-coupled transceiver tests
// Assumes: Test clock far slower than clk_i; pins arrive asynchronously
// Notes:   TCK edges are found by sampling, so the logic is all in clk_i domain
`timescale 1ns/1ps
// What this block does
// (R1) Every variant has the standard access port, the AC extension acts on transceiver pins only.
// (R2) Transceiver transmit and receive pairs have their own scan cells apart from the user I/O cells.
// (R3) The scan register length is fixed per variant, from 260 to 1632 cells, with 1006 for one package.
// (R4) The identity register is 32 bits: version, part number, maker code and a final 1.
// (R5) Two extra instructions drive edges on AC-coupled paths so receivers see transitions.
// (R6) Code 0010001111 in the instruction register selects the single-pulse AC test.
// (R7) Under the single pulse the driver shows the test data at the falling clock edge in update.
// (R8) Under the single pulse the driver shows inverted data at the falling edge after entering run-test/idle.
// (R9) Under the single pulse the driver restores true data at the falling edge after leaving run-test/idle.
// (R10) Code 0001001111 selects the pulse-train AC test, otherwise like the single pulse.
// (R11) Under the pulse train the output toggles at every falling edge while in run-test/idle.
// (R12) The port uses test data in, test data out, mode select and test clock.
// (R13) The instruction register is 10 bits and shifts least significant bit first.
// (R14) The identity register is chosen by its instruction and reset, and shifts out LSB first.
module scan_tap
  import scan_tap_pkg::*;
#(
  parameter int unsigned BSR_LEN = BSR_LEN_OPTION
)(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire tap_pins_t          pins_i,
  input  wire logic               rx_pair_i,
  output logic                    tdo_o,
  output logic                    tdo_oe_o,
  output logic                    tx_pair_o,
  output logic                    ac_mode_o
);

  tap_pins_t                 sync1_reg;
  tap_pins_t                 sync2_reg;
  logic                      tck_prev_reg;
  tap_state_t                state_reg;
  tap_state_t                state_next;
  logic [IR_WIDTH-1:0]       ir_shift_reg;
  logic [IR_WIDTH-1:0]       ir_reg;
  logic [ID_WIDTH-1:0]       id_reg;
  logic                      bypass_reg;
  logic [BSR_LEN-1:0]        bsr_reg;
  logic [BSR_LEN-1:0]        upd_reg;
  logic                      rise;
  logic                      fall;
  logic                      is_pulse;
  logic                      is_train;
  logic                      is_ac;
  logic                      is_ext;
  logic                      tdo_next;
  logic                      rx_meta_reg;
  logic                      rx_sync_reg;
  logic [IR_WIDTH-1:0]       ir_eff;

  function automatic tap_state_t tap_step(input tap_state_t s, input logic m);
    unique case (s)
      TEST_RESET: tap_step = m ? TEST_RESET : RUN_IDLE;
      RUN_IDLE:   tap_step = m ? SEL_DR : RUN_IDLE;
      SEL_DR:     tap_step = m ? SEL_IR : CAP_DR;
      CAP_DR:     tap_step = m ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR:   tap_step = m ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR:   tap_step = m ? UPD_DR : PAUSE_DR;
      PAUSE_DR:   tap_step = m ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR:   tap_step = m ? UPD_DR : SHIFT_DR;
      UPD_DR:     tap_step = m ? SEL_DR : RUN_IDLE;
      SEL_IR:     tap_step = m ? TEST_RESET : CAP_IR;
      CAP_IR:     tap_step = m ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR:   tap_step = m ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR:   tap_step = m ? UPD_IR : PAUSE_IR;
      PAUSE_IR:   tap_step = m ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR:   tap_step = m ? UPD_IR : SHIFT_IR;
      UPD_IR:     tap_step = m ? SEL_DR : RUN_IDLE;
    endcase
  endfunction

  // Two stages on every pin before anything looks at it (R12)
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      tck_prev_reg <= 1'b0;
      rx_meta_reg  <= 1'b0;
      rx_sync_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_reg    <= pins_i;
      sync2_reg    <= sync1_reg;
      tck_prev_reg <= sync2_reg.tck;
      rx_meta_reg  <= rx_pair_i;
      rx_sync_reg  <= rx_meta_reg;
    end
  end

  assign rise       = sync2_reg.tck & ~tck_prev_reg;
  assign fall       = ~sync2_reg.tck & tck_prev_reg;
  assign state_next = tap_step(state_reg, sync2_reg.tms);
  // New code acts from the Update-IR fall, so decode looks at it one half period early
  assign ir_eff     = (state_reg == UPD_IR) ? ir_shift_reg : ir_reg;
  assign is_pulse   = (ir_eff == IR_EXTEST_PULSE); // R6
  assign is_train   = (ir_eff == IR_EXTEST_TRAIN); // R10
  assign is_ac      = is_pulse | is_train; // R5
  assign is_ext     = is_ac | (ir_eff == IR_EXTEST);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      state_reg <= TEST_RESET;
    else if (ce_i && rise)
      state_reg <= state_next; // R1
  end

  // Instruction path, LSB first from TDI side (R13)
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ir_shift_reg <= '0;
      ir_reg       <= IR_RESET_VAL;
    end
    else if (ce_i)
    begin
      if (rise && state_reg == CAP_IR)
        ir_shift_reg <= IR_CAPTURE_VAL;
      else if (rise && state_reg == SHIFT_IR)
        ir_shift_reg <= {sync2_reg.tdi, ir_shift_reg[IR_WIDTH-1:1]}; // R13
      if (rise && state_reg == TEST_RESET)
        ir_reg <= IR_RESET_VAL; // R14
      else if (fall && state_reg == UPD_IR)
        ir_reg <= ir_shift_reg; // R7
    end
  end

  // Data registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      id_reg     <= '0;
      bypass_reg <= 1'b0;
      bsr_reg    <= '0;
    end
    else if (ce_i && rise)
    begin
      if (state_reg == CAP_DR)
      begin
        id_reg     <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // R4
        bypass_reg <= 1'b0;
        bsr_reg    <= bsr_reg;
        bsr_reg[RX_CELL] <= rx_sync_reg; // R2
        bsr_reg[TX_CELL] <= tx_pair_o; // R2
      end
      else if (state_reg == SHIFT_DR)
      begin
        if (ir_reg == IR_IDENT)
          id_reg <= {sync2_reg.tdi, id_reg[ID_WIDTH-1:1]}; // R14
        else if (ir_reg == IR_BYPASS)
          bypass_reg <= sync2_reg.tdi;
        else
          bsr_reg <= {sync2_reg.tdi, bsr_reg[BSR_LEN-1:1]}; // R3
      end
    end
  end

  // Update latches move on the falling edge, as the output stage does
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      upd_reg <= '0;
    else if (ce_i && fall && state_reg == UPD_DR && ir_reg != IR_IDENT && ir_reg != IR_BYPASS)
      upd_reg <= bsr_reg;
  end

  always_comb
  begin
    if (state_reg == SHIFT_IR)
      tdo_next = ir_shift_reg[0];
    else if (ir_reg == IR_IDENT)
      tdo_next = id_reg[0];
    else if (ir_reg == IR_BYPASS)
      tdo_next = bypass_reg;
    else
      tdo_next = bsr_reg[0];
  end

  // TDO changes on the falling edge only, so the tester samples a settled bit
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else if (ce_i && fall)
    begin
      tdo_o    <= tdo_next;
      tdo_oe_o <= (state_reg == SHIFT_IR) || (state_reg == SHIFT_DR); // R12
    end
  end

  // AC driver on the transceiver transmit pair only; user I/O keep level tests (R1)
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_pair_o <= 1'b0;
      ac_mode_o <= 1'b0;
    end
    else if (ce_i && fall)
    begin
      ac_mode_o <= is_ac;
      if (state_reg == TEST_RESET)
        tx_pair_o <= 1'b0;
      else if (is_ext && (state_reg == UPD_DR || state_reg == UPD_IR))
        tx_pair_o <= upd_bit(state_reg, bsr_reg[TX_CELL], upd_reg[TX_CELL]); // R7
      else if (is_ac && state_reg == RUN_IDLE)
      begin
        if (is_train)
          tx_pair_o <= ~tx_pair_o; // R11
        else
          tx_pair_o <= ~upd_reg[TX_CELL]; // R8
      end
      else if (is_ac)
        tx_pair_o <= upd_reg[TX_CELL]; // R9
    end
  end

  function automatic logic upd_bit(input tap_state_t s, input logic shift_bit, input logic held_bit);
    upd_bit = (s == UPD_DR) ? shift_bit : held_bit;
  endfunction

  logic in_idle_prev_reg;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      in_idle_prev_reg <= 1'b0;
    else if (ce_i && fall)
      in_idle_prev_reg <= (state_reg == RUN_IDLE);
  end

  AST_PULSE_INVERT: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    ce_i && fall && is_pulse && state_reg == RUN_IDLE |=> tx_pair_o == ~upd_reg[TX_CELL])
    else $error("pulse did not invert in idle");
  AST_PULSE_RESTORE: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    ce_i && fall && is_pulse && state_reg == SEL_DR && in_idle_prev_reg |=> tx_pair_o == upd_reg[TX_CELL])
    else $error("pulse did not restore after idle");
  AST_TRAIN_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    ce_i && fall && is_train && state_reg == RUN_IDLE |=> tx_pair_o != $past(tx_pair_o))
    else $error("train did not toggle");
  AST_UPDATE_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    ce_i && fall && is_ac && state_reg == UPD_DR |=> tx_pair_o == $past(bsr_reg[TX_CELL]))
    else $error("update did not drive data");
  AST_PULSE_DECODE: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    ce_i && fall && ir_reg == IR_EXTEST_PULSE && state_reg == RUN_IDLE && in_idle_prev_reg |=> $stable(tx_pair_o))
    else $error("pulse code behaved as a train");
  AST_TRAIN_DECODE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    ce_i && fall && ir_eff == IR_EXTEST_TRAIN |=> ac_mode_o)
    else $error("train code not decoded");
  AST_UPDIR_DRIVE: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    ce_i && fall && is_ac && state_reg == UPD_IR |=> tx_pair_o == upd_reg[TX_CELL])
    else $error("update ir did not drive data");
  AST_IR_SHIFT: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    ce_i && rise && state_reg == SHIFT_IR |=> ir_shift_reg[IR_WIDTH-1] == $past(sync2_reg.tdi))
    else $error("instruction shift wrong");
  AST_RESET_IDENT: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    ce_i && rise && state_reg == TEST_RESET |=> ir_reg == IR_IDENT)
    else $error("reset did not select identity");
  AST_ID_LSB: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    ce_i && rise && state_reg == CAP_DR && ir_reg == IR_IDENT |=> id_reg[0] == 1'b1)
    else $error("identity lsb not one");
  AST_ACMODE_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ce_i && fall |=> ac_mode_o == $past(is_ac))
    else $error("ac mode flag wrong");

  COV_PULSE: cover property (@(posedge clk_i) is_pulse && state_reg == RUN_IDLE && fall);
  COV_TRAIN: cover property (@(posedge clk_i) is_train && state_reg == RUN_IDLE && fall);
  COV_IDENT: cover property (@(posedge clk_i) ir_reg == IR_IDENT && state_reg == SHIFT_DR);

endmodule // scan_tap

/* core/scan_tap_pkg.sv */
// Purpose: Constants and types for the boundary-scan test access port
// Assumes: Test clock sampled by the 50 MHz system clock
// Notes:   Instruction codes other than the two AC tests are this block's own
package scan_tap_pkg;

  localparam int unsigned IR_WIDTH       = 10;
  localparam int unsigned ID_WIDTH       = 32;
  localparam int unsigned BSR_LEN_MIN    = 260;
  localparam int unsigned BSR_LEN_MAX    = 1632;
  localparam int unsigned BSR_LEN_OPTION = 1006;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned TX_CELL        = 0;
  localparam int unsigned RX_CELL        = 1;

  localparam logic [IR_WIDTH-1:0] IR_EXTEST_PULSE = 10'b00_1000_1111;
  localparam logic [IR_WIDTH-1:0] IR_EXTEST_TRAIN = 10'b00_0100_1111;
  localparam logic [IR_WIDTH-1:0] IR_EXTEST       = 10'b00_0000_1111;
  localparam logic [IR_WIDTH-1:0] IR_SAMPLE       = 10'b00_0000_0101;
  localparam logic [IR_WIDTH-1:0] IR_IDENT        = 10'b00_0000_0110;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS       = 10'b11_1111_1111;
  localparam logic [IR_WIDTH-1:0] IR_RESET_VAL    = IR_IDENT;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VAL  = 10'b00_0000_0001;

  // Identity fields: values arbitrary, not those of any real part
  localparam logic [3:0]  ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART    = 16'h1234;
  localparam logic [10:0] ID_MAKER   = 11'h2A5;

  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
    UPD_DR, SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

endpackage

/* test/jtag_tester.sv */
// Purpose: Behavioural boundary-scan tester that drives the test pins
// Assumes: TCK period of 160 ns that stays low between frames
// Notes:   TDO is sampled just before each TCK rise
`timescale 1ns/1ps
module jtag_tester
  import scan_tap_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic tdo_i,
  output tap_pins_t pins_o
);
  initial pins_o = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};

  task automatic half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // One TCK period; returns TDO as seen before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    pins_o.tms = tms;
    pins_o.tdi = tdi;
    half();
    tdo = tdo_i;
    pins_o.tck = 1'b1;
    half();
    pins_o.tck = 1'b0;
  endtask

  // TDI is not sampled here, so it flips to avoid holding a stale value
  task automatic reset_tap();
    logic d;
    repeat (5) tick(1'b1, ~pins_o.tdi, d);
    tick(1'b0, ~pins_o.tdi, d);
  endtask

  // From idle: n bits of v, zeros past bit 31, LSB first; stops in Exit1
  task automatic shift(input logic ir, input logic [31:0] v, input int n, output logic [31:0] got);
    logic d;
    got = '0;
    tick(1'b1, ~pins_o.tdi, d);
    if (ir)
    begin
      tick(1'b1, ~pins_o.tdi, d);
    end
    tick(1'b0, ~pins_o.tdi, d);
    tick(1'b0, ~pins_o.tdi, d);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, (i < 32) ? v[i] : 1'b0, d);
      if (i < 32)
      begin
        got[i] = d;
      end
    end
  endtask

  task automatic to_idle();
    logic d;
    tick(1'b1, ~pins_o.tdi, d);
    tick(1'b0, ~pins_o.tdi, d);
  endtask
endmodule // jtag_tester

/* test/tb_top.sv */
// Purpose: Self-checking bench for the boundary-scan access port
// Assumes: Shortest scan register so that full shifts stay quick
// Notes:   Clock enable dropped once across a whole test-clock period
`timescale 1ns/1ps
module tb_top
  import scan_tap_pkg::*;
;
  localparam int unsigned LEN = 260;
  logic        clk_i           = 1'b0;
  logic        rst_i           = 1'b1;
  logic        ce_i            = 1'b1;
  logic        rx_pair_i       = 1'b0;
  tap_pins_t   pins;
  logic        tdo_o;
  logic        tdo_oe_o;
  logic        tx_pair_o;
  logic        ac_mode_o;
  int          failures        = 0;
  int          samples_checked = 0;
  logic [31:0] got;

  always #10 clk_i = ~clk_i;

  scan_tap #(.BSR_LEN(LEN)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pins_i(pins),
    .rx_pair_i(rx_pair_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .tx_pair_o(tx_pair_o), .ac_mode_o(ac_mode_o));
  jtag_tester tester (.clk_i(clk_i), .tdo_i(tdo_o), .pins_o(pins));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Outputs move 3-4 clocks after a TCK fall
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  task automatic step(input logic tms, input logic exp_tx);
    logic d;
    tester.tick(tms, 1'b0, d);
    settle();
    check(tx_pair_o, exp_tx);
  endtask

  // Prev is the held update data that Update-IR drives
  task automatic ac_run(input logic [9:0] code, input logic prev, input logic [4:0] exp);
    tester.shift(1'b1, {22'h0, code}, 10, got);
    check(got[9:0], IR_CAPTURE_VAL);
    step(1'b1, prev);
    step(1'b0, ~prev);
    check(ac_mode_o, 1'b1);
    tester.shift(1'b0, 32'h0000_0001, LEN, got);
    for (int i = 0; i < 5; i++)
    begin
      step(i == 0 || i == 4, exp[i]);
    end
    tester.reset_tap();
    settle();
    check(ac_mode_o, 1'b0);
    check(tx_pair_o, 1'b0);
  endtask

  task automatic test_pulse();
    ac_run(IR_EXTEST_PULSE, 1'b0, 5'b1_0001);
  endtask

  // Idle falls toggle, so the third step differs from the single pulse
  task automatic test_train();
    ac_run(IR_EXTEST_TRAIN, 1'b1, 5'b1_0101);
  endtask

  // A whole test-clock period with the enable low must leave the controller in idle
  task automatic test_freeze();
    logic d;
    tester.reset_tap();
    settle();
    ce_i = 1'b0;
    tester.tick(1'b1, 1'b1, d);
    settle();
    ce_i = 1'b1;
    tester.shift(1'b0, 32'h0000_0000, 32, got);
    tester.to_idle();
    check(got, {ID_VERSION, ID_PART, ID_MAKER, 1'b1});
  endtask

  task automatic test_ident();
    tester.reset_tap();
    tester.shift(1'b0, 32'h0000_0000, 32, got);
    tester.to_idle();
    check(got, {ID_VERSION, ID_PART, ID_MAKER, 1'b1});
    check(got[0], 1'b1);
    settle();
    check(tdo_oe_o, 1'b0);
  endtask

  task automatic test_bypass();
    logic [31:0] v;
    v = 32'hA5C3_0F69;
    tester.shift(1'b1, {22'h0, IR_BYPASS}, 10, got);
    tester.to_idle();
    tester.shift(1'b0, v, 32, got);
    tester.to_idle();
    check(got, {v[30:0], 1'b0});
  endtask

  task automatic test_rx_capture();
    tester.shift(1'b1, {22'h0, IR_SAMPLE}, 10, got);
    tester.to_idle();
    for (int k = 0; k < 2; k++)
    begin
      rx_pair_i = k[0];
      tester.shift(1'b0, 32'h0000_0000, LEN, got);
      tester.to_idle();
      check(got[1], k[0]);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    test_ident();
    test_pulse();
    test_train();
    test_bypass();
    test_rx_capture();
    test_freeze();
    test_ident();
    report_and_stop();
  end

  // Whole run needs well under 0.5 ms
  initial
  begin
    #1_500_000;
    failures++;
    report_and_stop();
  end
endmodule // tb_top
